// *** core/lmp_defines.svh ***
// constants for the led matrix pwm dimming core
// Summary of operation
// - every dot keeps its own duty, 8-bit or 16-bit by refresh mode
// - two-bit group selector per dot; 00 none, 01..11 groups one to three
// - one global 8-bit duty scales every dot at once
// - effective duty is individual times group times global duty
// - pwm rate selectable between 125kHz and 62.5kHz by one config bit
// - all pwm timing comes from a 32MHz internal oscillator tick
// - sinks split into three phases by index mod 3, 125ns apart when enabled
// - optional sink turn-on delay of one internal clock after line turn-on
// - scale bit picks linear or fixed exponential mapping at both depths
// - each dot has a one-bit on/off control written by registers
// - mode 1 applies 8-bit writes at once; unwritten dots keep values
// - modes 2 and 3 hold data and apply the whole frame on frame sync
// - 16-bit and 8-bit duty storage live at different addresses
// - memory writable while displayed; host accesses auto-increment
// - open fault needs duty threshold and 4 consecutive low sub-periods
// - open fault sets global and per-dot flags; writing 0Fh clears them
// - open removal turns off an open dot's sink on its line
// - short fault needs duty threshold and 4 consecutive high sub-periods
// - short fault sets global and per-dot flags; writing 0Fh clears them
// - short removal disables upside deghosting on lines with shorted dots
// - over-temperature stops all outputs until the indication clears
// - sink active time per line slot is 8us or 16us by pwm rate
`ifndef LMP_DEFINES_SVH
`define LMP_DEFINES_SVH
`define LMP_SINKS 18
`define LMP_LINES 11
`define LMP_DOTS 198
`define LMP_LAST_LINE 4'd10
`define LMP_LAST_IDX 8'd197
`define LMP_CLK_MHZ 200
`define LMP_OSC_MHZ 32
`define LMP_ACC_STEP 9'(`LMP_OSC_MHZ)
`define LMP_ACC_MOD 9'(`LMP_CLK_MHZ)
`define LMP_OSC_PS 31250
`define LMP_T_PHASE_NS 125
`define LMP_T_BLANK_NS 1000
`define LMP_T_ACT_FAST_NS 8000
`define LMP_T_ACT_SLOW_NS 16000
`define LMP_T_ICLK_FAST_PS 31250
`define LMP_T_ICLK_SLOW_PS 62500
`define LMP_TK(ns) 10'(((ns) * 1000) / `LMP_OSC_PS)
`define LMP_PHASE_TICKS `LMP_TK(`LMP_T_PHASE_NS)
`define LMP_BLANK_TICKS `LMP_TK(`LMP_T_BLANK_NS)
`define LMP_ACT_FAST `LMP_TK(`LMP_T_ACT_FAST_NS)
`define LMP_ACT_SLOW `LMP_TK(`LMP_T_ACT_SLOW_NS)
`define LMP_ICLK_FAST 10'(`LMP_T_ICLK_FAST_PS / `LMP_OSC_PS)
`define LMP_ICLK_SLOW 10'(`LMP_T_ICLK_SLOW_PS / `LMP_OSC_PS)
`define LMP_FULL 8'hff
`define LMP_NORM 32'd65025
`define LMP_DET8 8'd25
`define LMP_DET16 16'd6400
`define LMP_FAULT_RUN 2'd3
`define LMP_CLR_CODE 8'h0f
`define LMP_CTRL_RST 8'h00
`define LMP_A_CTRL 8'h00
`define LMP_A_GLOBAL 8'h04
`define LMP_A_GRP1 8'h08
`define LMP_A_GRP2 8'h0c
`define LMP_A_GRP3 8'h10
`define LMP_A_OPEN_CLR 8'h14
`define LMP_A_SHORT_CLR 8'h18
`define LMP_A_STATUS 8'h1c
`define LMP_A_PTR 8'h20
`define LMP_A_DATA 8'h24
`define LMP_RG_DUTY8 3'h0
`define LMP_RG_DUTY16 3'h1
`define LMP_RG_GROUP 3'h2
`define LMP_RG_ONOFF 3'h3
`define LMP_RG_OPEN 3'h4
`define LMP_RG_SHORT 3'h5
`define LMP_RESP_OKAY 2'h0
`define LMP_RESP_SLVERR 2'h2
`endif

// *** core/lmp_pkg.sv ***
// types for the led matrix pwm dimming core
package lmp_pkg;
  typedef struct packed {
    logic       short_line_removal;
    logic       open_channel_removal;
    logic       cs_on_shift;
    logic       phase_shift;
    logic       scale_exp;
    logic [1:0] ref_mode;
    logic       fre_slow;
  } lmp_cfg_t;
  typedef struct packed {
    logic [2:0] region;
    logic [7:0] idx;
  } lmp_ptr_t;
  typedef struct packed {
    logic over_temp;
    logic any_short_flag;
    logic any_open_flag;
  } lmp_status_t;
  typedef enum logic [1:0] {
    LMP_BLANK  = 2'b01,
    LMP_ACTIVE = 2'b10
  } lmp_state_t;
endpackage

// *** core/lmp_core.sv ***
// led matrix pwm dimming, refresh and fault core with axi4-lite slave
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lmp_defines.svh"
module lmp_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        undervoltage,
  input  wire logic        over_temp,
  input  wire logic        frame_sync,
  input  wire logic [17:0] sink_below_open,
  input  wire logic [17:0] sink_above_short,
  output logic [17:0]      current_sink_pin,
  output logic [10:0]      scan_line,
  output logic             up_deghost_en
);
  logic                 rst;
  lmp_pkg::lmp_cfg_t    cfg_q;
  logic [7:0]           glob_q;
  logic [7:0]           grp_q [3];
  lmp_pkg::lmp_ptr_t    ptr_q;
  logic [7:0]           wr8 [`LMP_DOTS];
  logic [7:0]           disp8 [`LMP_DOTS];
  logic [15:0]          wr16 [`LMP_DOTS];
  logic [15:0]          disp16 [`LMP_DOTS];
  logic [1:0]           grp_sel [`LMP_DOTS];
  logic                 onoff [`LMP_DOTS];
  logic                 open_flag [`LMP_DOTS];
  logic                 short_flag [`LMP_DOTS];
  logic [1:0]           open_cnt [`LMP_DOTS];
  logic [1:0]           short_cnt [`LMP_DOTS];
  logic                 any_open_q;
  logic                 any_short_q;
  logic                 aw_hold_q;
  logic                 w_hold_q;
  logic [7:0]           awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 wr_fire;
  logic [7:0]           wa;
  logic                 wr_err;
  logic                 rd_fire;
  logic                 rd_err;
  logic [31:0]          rd_word;
  logic [31:0]          mem_rd;
  logic                 idx_ok;
  logic                 mem_wr;
  logic                 mem_rd_inc;
  logic                 clr_open;
  logic                 clr_short;
  logic                 mode3;
  logic                 frame_mode;
  logic                 sync_q;
  logic                 frame_edge;
  logic [8:0]           acc_q;
  logic [8:0]           acc_sum;
  logic                 tick;
  lmp_pkg::lmp_state_t  state_q;
  logic [9:0]           tcnt_q;
  logic [3:0]           line_q;
  logic [7:0]           subp_q;
  logic [9:0]           period_ticks;
  logic [9:0]           shift_ticks;
  logic [9:0]           phase_ticks;
  logic [9:0]           act_len;
  logic                 slot_end;
  logic [7:0]           line_base;
  logic [17:0]          sink_on;
  logic [17:0]          open_hit;
  logic [17:0]          short_hit;
  logic [17:0]          open_full;
  logic [17:0]          short_full;
  logic [17:0]          line_short;
  logic                 set_open;
  logic                 set_short;
  logic [7:0]           lane_dot [`LMP_SINKS];

  assign rst = !aresetn || undervoltage;
  assign mode3 = cfg_q.ref_mode[1];
  assign frame_mode = |cfg_q.ref_mode;

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign wr_fire = aw_hold_q && w_hold_q;
  assign wa = {awaddr_q[7:2], 2'b00};
  assign wr_err = (wa > `LMP_A_DATA);
  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LMP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `LMP_RESP_SLVERR : `LMP_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; only byte lane 0 carries them
  assign clr_open = wr_fire && wstrb_q[0] && wa == `LMP_A_OPEN_CLR
                    && wdata_q[7:0] == `LMP_CLR_CODE;
  assign clr_short = wr_fire && wstrb_q[0] && wa == `LMP_A_SHORT_CLR
                     && wdata_q[7:0] == `LMP_CLR_CODE;
  always_ff @(posedge aclk) begin
    if (rst) begin
      cfg_q <= lmp_pkg::lmp_cfg_t'(`LMP_CTRL_RST);
      glob_q <= `LMP_FULL;
      for (int g = 0; g < 3; g++) begin
        grp_q[g] <= `LMP_FULL;
      end
    end else if (wr_fire && wstrb_q[0]) begin
      case (wa)
        `LMP_A_CTRL:   cfg_q <= lmp_pkg::lmp_cfg_t'(wdata_q[7:0]);
        `LMP_A_GLOBAL: glob_q <= wdata_q[7:0];
        `LMP_A_GRP1:   grp_q[0] <= wdata_q[7:0];
        `LMP_A_GRP2:   grp_q[1] <= wdata_q[7:0];
        `LMP_A_GRP3:   grp_q[2] <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // pointer into dot memory, auto-incrementing on data port use
  assign idx_ok = ptr_q.idx <= `LMP_LAST_IDX;
  assign mem_wr = wr_fire && wstrb_q[0] && wa == `LMP_A_DATA && idx_ok;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign mem_rd_inc = rd_fire && {s_axi_araddr[7:2], 2'b00} == `LMP_A_DATA;
  always_ff @(posedge aclk) begin
    if (rst) begin
      ptr_q <= '0;
    end else if (wr_fire && wstrb_q[0] && wa == `LMP_A_PTR) begin
      ptr_q <= lmp_pkg::lmp_ptr_t'(wdata_q[10:0]);
    end else if ((wr_fire && wa == `LMP_A_DATA) || mem_rd_inc) begin
      ptr_q.idx <= (ptr_q.idx >= `LMP_LAST_IDX) ? 8'h00 : ptr_q.idx + 8'd1;
    end
  end

  // dot memory; write copies and display copies, separate 8 and 16 bit stores
  assign frame_edge = frame_sync && !sync_q;
  always_ff @(posedge aclk) begin
    if (rst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= frame_sync;
    end
  end
  always_ff @(posedge aclk) begin
    if (rst) begin
      for (int i = 0; i < `LMP_DOTS; i++) begin
        wr8[i] <= 8'h00;
        disp8[i] <= 8'h00;
        wr16[i] <= 16'h0000;
        disp16[i] <= 16'h0000;
        grp_sel[i] <= 2'b00;
        onoff[i] <= 1'b0;
      end
    end else begin
      if (frame_edge && frame_mode) begin
        for (int i = 0; i < `LMP_DOTS; i++) begin
          disp8[i] <= wr8[i];
          disp16[i] <= wr16[i];
        end
      end
      if (mem_wr) begin
        case (ptr_q.region)
          `LMP_RG_DUTY8: begin
            wr8[ptr_q.idx] <= wdata_q[7:0];
            if (!frame_mode) begin
              disp8[ptr_q.idx] <= wdata_q[7:0];
            end
          end
          `LMP_RG_DUTY16: wr16[ptr_q.idx] <= wdata_q[15:0];
          `LMP_RG_GROUP:  grp_sel[ptr_q.idx] <= wdata_q[1:0];
          `LMP_RG_ONOFF:  onoff[ptr_q.idx] <= wdata_q[0];
          default: ;
        endcase
      end
    end
  end

  // axi4-lite read: one cycle from address to data
  always_comb begin
    mem_rd = 32'h0;
    if (idx_ok) begin
      case (ptr_q.region)
        `LMP_RG_DUTY8:  mem_rd = {24'h0, wr8[ptr_q.idx]};
        `LMP_RG_DUTY16: mem_rd = {16'h0, wr16[ptr_q.idx]};
        `LMP_RG_GROUP:  mem_rd = {30'h0, grp_sel[ptr_q.idx]};
        `LMP_RG_ONOFF:  mem_rd = {31'h0, onoff[ptr_q.idx]};
        `LMP_RG_OPEN:   mem_rd = {31'h0, open_flag[ptr_q.idx]};
        `LMP_RG_SHORT:  mem_rd = {31'h0, short_flag[ptr_q.idx]};
        default:        mem_rd = 32'h0;
      endcase
    end
  end
  always_comb begin
    rd_word = 32'h0;
    rd_err = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      `LMP_A_CTRL:      rd_word = {24'h0, cfg_q};
      `LMP_A_GLOBAL:    rd_word = {24'h0, glob_q};
      `LMP_A_GRP1:      rd_word = {24'h0, grp_q[0]};
      `LMP_A_GRP2:      rd_word = {24'h0, grp_q[1]};
      `LMP_A_GRP3:      rd_word = {24'h0, grp_q[2]};
      `LMP_A_OPEN_CLR:  rd_word = 32'h0;
      `LMP_A_SHORT_CLR: rd_word = 32'h0;
      `LMP_A_STATUS:    rd_word = {29'h0, lmp_pkg::lmp_status_t'({over_temp, any_short_q,
                                                                  any_open_q})};
      `LMP_A_PTR:       rd_word = {21'h0, ptr_q};
      `LMP_A_DATA:      rd_word = mem_rd;
      default:          rd_err = 1'b1;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `LMP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_err ? `LMP_RESP_SLVERR : `LMP_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // 32MHz tick from the 200MHz clock by fractional accumulation
  assign acc_sum = acc_q + `LMP_ACC_STEP;
  assign tick = acc_sum >= `LMP_ACC_MOD;
  always_ff @(posedge aclk) begin
    if (rst) begin
      acc_q <= 9'h000;
    end else begin
      acc_q <= tick ? acc_sum - `LMP_ACC_MOD : acc_sum;
    end
  end

  // line slot timing, counted in oscillator ticks
  assign period_ticks = cfg_q.fre_slow ? `LMP_ACT_SLOW : `LMP_ACT_FAST;
  assign shift_ticks = !cfg_q.cs_on_shift ? 10'h000 :
                       (cfg_q.fre_slow ? `LMP_ICLK_SLOW : `LMP_ICLK_FAST);
  assign phase_ticks = cfg_q.phase_shift ? `LMP_PHASE_TICKS : 10'h000;
  assign act_len = period_ticks + shift_ticks + phase_ticks + phase_ticks;
  assign slot_end = tick && state_q == lmp_pkg::LMP_ACTIVE && tcnt_q == act_len - 10'd1;
  assign line_base = 8'({4'h0, line_q} * 8'(`LMP_SINKS));
  always_ff @(posedge aclk) begin
    if (rst) begin
      state_q <= lmp_pkg::LMP_BLANK;
      tcnt_q <= 10'h000;
      line_q <= 4'h0;
      subp_q <= 8'h00;
    end else if (tick) begin
      case (state_q)
        lmp_pkg::LMP_BLANK: begin
          tcnt_q <= tcnt_q + 10'd1;
          if (tcnt_q == `LMP_BLANK_TICKS - 10'd1) begin
            state_q <= lmp_pkg::LMP_ACTIVE;
            tcnt_q <= 10'h000;
          end
        end
        lmp_pkg::LMP_ACTIVE: begin
          tcnt_q <= tcnt_q + 10'd1;
          if (slot_end) begin
            state_q <= lmp_pkg::LMP_BLANK;
            tcnt_q <= 10'h000;
            line_q <= (line_q == `LMP_LAST_LINE) ? 4'h0 : line_q + 4'd1;
            if (line_q == `LMP_LAST_LINE) begin
              subp_q <= subp_q + 8'd1;
            end
          end
        end
        default: begin
          state_q <= lmp_pkg::LMP_BLANK;
          tcnt_q <= 10'h000;
        end
      endcase
    end
  end

  // one lane per current sink serving the dot of the current line
  for (genvar k = 0; k < `LMP_SINKS; k++) begin : g_sink
    logic [7:0]  di;
    logic [15:0] raw;
    logic [31:0] sq;
    logic [15:0] scl;
    logic [7:0]  gd;
    logic [31:0] prod;
    logic [15:0] eff;
    logic [9:0]  off;
    logic [9:0]  rel;
    logic [7:0]  pos;
    logic [8:0]  lim;
    logic        in_win;
    logic        det_en;
    logic        drv_q;
    logic        low_q;
    logic        high_q;
    assign di = line_base + 8'(k);
    assign lane_dot[k] = di;
    assign raw = mode3 ? disp16[di] : {disp8[di], disp8[di]};
    assign sq = {16'h0, raw} * {16'h0, raw};
    assign scl = cfg_q.scale_exp ? sq[31:16] : raw;
    assign gd = (grp_sel[di] == 2'b00) ? `LMP_FULL : grp_q[grp_sel[di] - 2'd1];
    assign prod = {16'h0, scl} * {24'h0, gd} * {24'h0, glob_q};
    assign eff = 16'(prod / `LMP_NORM);
    assign off = shift_ticks + 10'(k % 3) * phase_ticks;
    assign rel = tcnt_q - off;
    assign in_win = state_q == lmp_pkg::LMP_ACTIVE && tcnt_q >= off && rel < period_ticks;
    assign pos = cfg_q.fre_slow ? rel[8:1] : rel[7:0];
    // low byte dithered over sub-periods as spread_spectrum_duty
    assign lim = {1'b0, eff[15:8]} + {8'h00, subp_q < eff[7:0]};
    assign sink_on[k] = in_win && {1'b0, pos} < lim && onoff[di]
                        && !(cfg_q.open_channel_removal && open_flag[di])
                        && !over_temp;
    assign det_en = mode3 ? disp16[di] >= `LMP_DET16 : disp8[di] >= `LMP_DET8;
    assign open_hit[k] = det_en && drv_q && low_q;
    assign short_hit[k] = det_en && drv_q && high_q;
    assign open_full[k] = open_cnt[di] == `LMP_FAULT_RUN;
    assign short_full[k] = short_cnt[di] == `LMP_FAULT_RUN;
    assign line_short[k] = short_flag[di];
    // comparator must hold the whole on time, not just one sample
    always_ff @(posedge aclk) begin
      if (rst || state_q == lmp_pkg::LMP_BLANK) begin
        drv_q <= 1'b0;
        low_q <= 1'b1;
        high_q <= 1'b1;
      end else if (sink_on[k]) begin
        drv_q <= 1'b1;
        low_q <= low_q && sink_below_open[k];
        high_q <= high_q && sink_above_short[k];
      end
    end
  end

  // fault flags; a set in the clearing cycle wins
  assign set_open = slot_end && |(open_hit & open_full);
  assign set_short = slot_end && |(short_hit & short_full);
  always_ff @(posedge aclk) begin
    if (rst) begin
      for (int i = 0; i < `LMP_DOTS; i++) begin
        open_flag[i] <= 1'b0;
        short_flag[i] <= 1'b0;
        open_cnt[i] <= 2'b00;
        short_cnt[i] <= 2'b00;
      end
      any_open_q <= 1'b0;
      any_short_q <= 1'b0;
    end else begin
      if (clr_open) begin
        any_open_q <= 1'b0;
        for (int i = 0; i < `LMP_DOTS; i++) begin
          open_flag[i] <= 1'b0;
          open_cnt[i] <= 2'b00;
        end
      end
      if (clr_short) begin
        any_short_q <= 1'b0;
        for (int i = 0; i < `LMP_DOTS; i++) begin
          short_flag[i] <= 1'b0;
          short_cnt[i] <= 2'b00;
        end
      end
      if (slot_end) begin
        for (int k = 0; k < `LMP_SINKS; k++) begin
          if (!open_hit[k]) begin
            open_cnt[lane_dot[k]] <= 2'b00;
          end else if (open_full[k]) begin
            open_flag[lane_dot[k]] <= 1'b1;
            any_open_q <= 1'b1;
          end else begin
            open_cnt[lane_dot[k]] <= open_cnt[lane_dot[k]] + 2'd1;
          end
          if (!short_hit[k]) begin
            short_cnt[lane_dot[k]] <= 2'b00;
          end else if (short_full[k]) begin
            short_flag[lane_dot[k]] <= 1'b1;
            any_short_q <= 1'b1;
          end else begin
            short_cnt[lane_dot[k]] <= short_cnt[lane_dot[k]] + 2'd1;
          end
        end
      end
    end
  end

  // registered pins
  always_ff @(posedge aclk) begin
    if (rst) begin
      current_sink_pin <= 18'h00000;
      scan_line <= 11'h000;
      up_deghost_en <= 1'b0;
    end else begin
      current_sink_pin <= sink_on;
      scan_line <= (state_q == lmp_pkg::LMP_ACTIVE && !over_temp) ?
                   11'h001 << line_q : 11'h000;
      up_deghost_en <= state_q == lmp_pkg::LMP_BLANK && !over_temp
                       && !(cfg_q.short_line_removal && |line_short);
    end
  end

  // checks
  logic [7:0]  h_idx_q;
  logic [7:0]  h_dat_q;
  logic [15:0] h16_q;
  always_ff @(posedge aclk) begin
    h_idx_q <= ptr_q.idx;
    h_dat_q <= wdata_q[7:0];
    h16_q <= wr16[0];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_frame;
    frame_edge && frame_mode && !undervoltage;
  endsequence
  sequence s_instant;
    mem_wr && ptr_q.region == `LMP_RG_DUTY8 && !frame_mode && !undervoltage;
  endsequence
  a_osc_tick_gap: assert property (tick |=> !tick [*5])
    else $error("oscillator tick faster than 32MHz");
  a_blank_sinks_off: assert property (state_q == lmp_pkg::LMP_BLANK && !undervoltage
    |=> current_sink_pin == 18'h00000)
    else $error("sink on during blank");
  a_thermal_dark: assert property (over_temp && !undervoltage
    |=> current_sink_pin == 18'h00000 && scan_line == 11'h000)
    else $error("outputs driven in thermal shutdown");
  a_uv_holds_reset: assert property (undervoltage
    |=> state_q == lmp_pkg::LMP_BLANK && line_q == 4'h0 && !any_open_q)
    else $error("logic not held under undervoltage");
  a_open_flag_set: assert property (set_open && !undervoltage |=> any_open_q)
    else $error("open fault not flagged");
  a_open_flag_clear: assert property (clr_open && !set_open && !undervoltage
    |=> !any_open_q)
    else $error("open flag not cleared");
  a_short_flag_set: assert property (set_short && !undervoltage |=> any_short_q)
    else $error("short fault not flagged");
  a_short_flag_clear: assert property (clr_short && !set_short && !undervoltage
    |=> !any_short_q)
    else $error("short flag not cleared");
  a_phase_two_late: assert property (cfg_q.phase_shift && !cfg_q.cs_on_shift
    && state_q == lmp_pkg::LMP_ACTIVE && tcnt_q < `LMP_PHASE_TICKS && !undervoltage
    |=> !current_sink_pin[1])
    else $error("phase two sink on too early");
  a_mode1_instant: assert property (s_instant |=> disp8[h_idx_q] == h_dat_q)
    else $error("mode 1 write not applied at once");
  a_frame_applied: assert property (s_frame |=> disp16[0] == h16_q)
    else $error("frame not applied on sync");
endmodule

// *** tb/lmp_sink_model.sv ***
// sink comparators and frame sync source facing the core
`timescale 1ns/1ps
module lmp_sink_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [17:0] open_mask,
  input  wire logic [17:0] short_mask,
  input  wire logic        sync_req,
  output logic [17:0]      sink_below_open,
  output logic [17:0]      sink_above_short,
  output logic             frame_sync
);
  logic [3:0] cnt_q;
  // a faulty dot holds its comparator for the whole slot
  assign sink_below_open  = open_mask;
  assign sink_above_short = short_mask;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
    end else if (sync_req) begin
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // pulse stays high for eight cycles, well above the sampling edge
  assign frame_sync = (cnt_q != 4'h0);
endmodule

// *** tb/lmp_core_tb.sv ***
// self-checking bench for the led matrix pwm dimming core
`timescale 1ns/1ps
`include "lmp_defines.svh"
module lmp_core_tb;
  logic        aclk, aresetn, uv, ot, sreq, fsync, dgh;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, seen;
  logic [1:0]  bresp, rresp, rs;
  logic [17:0] pin, opn, shr, omask, smask;
  logic [10:0] line;
  int          bad_count, samples_checked;
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  lmp_sink_model i_model (.aclk(aclk), .aresetn(aresetn), .open_mask(omask),
    .short_mask(smask), .sync_req(sreq), .sink_below_open(opn), .sink_above_short(shr),
    .frame_sync(fsync));
  lmp_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .undervoltage(uv),
    .over_temp(ot), .frame_sync(fsync), .sink_below_open(opn), .sink_above_short(shr),
    .current_sink_pin(pin), .scan_line(line), .up_deghost_en(dgh));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  // requests move just after a rising edge; answers are taken at the edge they stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      done = bvalid & bready;
      if (awvalid & awready) awvalid <= 1'b0;
      if (wvalid & wready) wvalid <= 1'b0;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    logic done;
    araddr <= a;
    arvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      done = rvalid & rready;
      if (done) begin
        rd = rdata;
        rs = rresp;
      end
      if (arvalid & arready) arvalid <= 1'b0;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    bad_count++;
    print_verdict;
  end
  initial begin
    {uv, ot, sreq, omask, smask, awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    {bready, rready, aresetn} = 3'b110;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`LMP_A_GLOBAL);
    chk(rd, 32'h0000_00ff);
    rdr(8'h28);
    chk({30'h0, rs}, {30'h0, `LMP_RESP_SLVERR});
    $display("reset values done");
    for (int r = 0; r < 3; r++) begin
      wr(`LMP_A_PTR, {21'h0, 3'(r), 8'(r == 2 ? 0 : 196)});
      for (int i = 0; i < 4; i++) wr(`LMP_A_DATA, r == 2 ? i : 32'h11 * (i + 1));
      wr(`LMP_A_PTR, {21'h0, 3'(r), 8'(r == 2 ? 0 : 196)});
      for (int i = 0; i < 4; i++) begin
        rdr(`LMP_A_DATA);
        chk(rd, r == 2 ? i : 32'h11 * (i + 1));
      end
    end
    $display("memory access done");
    wr(`LMP_A_PTR, {21'h0, `LMP_RG_ONOFF, 8'd0});
    wr(`LMP_A_DATA, 32'h1);
    wr(`LMP_A_DATA, 32'h1);
    omask <= 18'h1;
    smask <= 18'h1;
    for (int n = 0; n < 25000 && !pin[0]; n++) @(posedge aclk);
    chk({31'h0, pin[0]}, 32'h1);
    wait (!line[0]);
    repeat (3) @(posedge aclk);
    chk({31'h0, dgh}, 32'h1);
    rd = '0;
    for (int n = 0; n < 40 && !rd[0]; n++) begin
      repeat (2000) @(posedge aclk);
      rdr(`LMP_A_STATUS);
    end
    chk(rd, 32'h3);
    wr(`LMP_A_CTRL, 32'hd8);
    wait (line[10]);
    wait (!line[10]);
    repeat (3) @(posedge aclk);
    chk({31'h0, dgh}, 32'h0);
    seen = 1'b0;
    repeat (2000) @(posedge aclk) seen |= pin[0];
    chk({31'h0, seen}, 32'h0);
    omask <= 18'h0;
    smask <= 18'h0;
    wr(`LMP_A_OPEN_CLR, {24'h0, `LMP_CLR_CODE});
    wr(`LMP_A_SHORT_CLR, {24'h0, `LMP_CLR_CODE});
    rdr(`LMP_A_STATUS);
    chk(rd, 32'h0);
    $display("fault detection done");
    wr(`LMP_A_CTRL, 32'h25);
    sreq <= 1'b1;
    @(posedge aclk);
    sreq <= 1'b0;
    repeat (12) @(posedge aclk);
    $display("frame sync done");
    ot <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({2'h0, dgh, pin, line}, 32'h0);
    ot <= 1'b0;
    wr(`LMP_A_GLOBAL, 32'h40);
    rdr(`LMP_A_GLOBAL);
    chk(rd, 32'h0000_0040);
    uv <= 1'b1;
    @(posedge aclk);
    uv <= 1'b0;
    rdr(`LMP_A_GLOBAL);
    chk(rd, 32'h0000_00ff);
    $display("shutdown and undervoltage done");
    print_verdict;
  end
endmodule
